// ===== rtl/ifc_pkg.sv
// Shared constants and types of the flash programming control block.
// Assumes a 32-bit AXI4-Lite register bus with byte offsets below.
package ifc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR_LO  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HI  = 8'h04;
    localparam logic [7:0] OFS_D0_LO    = 8'h08;
    localparam logic [7:0] OFS_D0_HI    = 8'h0c;
    localparam logic [7:0] OFS_D1_LO    = 8'h10;
    localparam logic [7:0] OFS_D1_HI    = 8'h14;
    localparam logic [7:0] OFS_D2_LO    = 8'h18;
    localparam logic [7:0] OFS_D2_HI    = 8'h1c;
    localparam logic [7:0] OFS_D3_LO    = 8'h20;
    localparam logic [7:0] OFS_D3_HI    = 8'h24;
    localparam logic [7:0] OFS_OP_CTRL  = 8'h28;
    localparam logic [7:0] OFS_CHIP_KEY = 8'h2c;
    localparam logic [7:0] OFS_BUF_CLR  = 8'h30;

    // ------------------------------------------------------------------
    // Field positions, codes and values
    // ------------------------------------------------------------------
    localparam int EWEN_BIT  = 7;
    localparam int MODE_LSB  = 4;
    localparam int TRIG_BIT  = 3;
    localparam int WINIT_BIT = 2;
    localparam int RDEN_BIT  = 1;
    localparam int RINIT_BIT = 0;
    localparam int CLR_BIT   = 0;
    localparam logic [2:0] MODE_WRITE  = 3'h0;
    localparam logic [2:0] MODE_ERASE  = 3'h1;
    localparam logic [2:0] MODE_READ   = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    localparam logic [7:0] KEY1_LO = 8'h00;
    localparam logic [7:0] KEY2_LO = 8'h0d;
    localparam logic [7:0] KEY3_LO = 8'hc3;
    localparam logic [7:0] KEY1_HI = 8'h04;
    localparam logic [7:0] KEY2_HI = 8'h09;
    localparam logic [7:0] KEY3_HI = 8'h40;
    localparam logic [7:0] CHIP_RST_KEY = 8'h55;
    localparam logic [4:0] PAGE_LAST    = 5'h1f;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam int TMR_W = 24;
    localparam logic [TMR_W-1:0] UNLOCK_CYC_DEF = 24'h3e8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_ERASE, PH_FETCH, PH_PROG, PH_READ, PH_CLEAR
    } ifc_phase_t;

    typedef enum logic [1:0] {FC_NONE, FC_ERASE, FC_PROG, FC_READ} ifc_fcmd_t;

    // Request to the flash array, held until acknowledged
    typedef struct packed {
        logic        valid;
        ifc_fcmd_t   cmd;
        logic [12:0] addr;
        logic [15:0] data;
    } ifc_flash_req_t;

    typedef struct packed {
        logic             aw_rdy;
        logic             b_vld;
        logic [1:0]       b_resp;
        logic             ar_rdy;
        logic             r_vld;
        logic [1:0]       r_resp;
        logic [7:0]       r_data;
        logic [12:0]      addr;
        logic [3:0][7:0]  lo;
        logic [3:0][7:0]  hi;
        logic             ew_en;
        logic [2:0]       mode;
        logic             trig;
        logic             winit;
        logic             rden;
        logic             rinit;
        logic [7:0]       chip_key;
        logic             clr;
        logic [TMR_W-1:0] timer;
        ifc_phase_t       phase;
        logic [4:0]       idx;
        ifc_flash_req_t   freq;
        logic             stall;
        logic             chip_rst;
    } ifc_state_t;

endpackage

// ===== rtl/ifc_wbuf.sv
// Page write buffer: one write port, one registered read port.
// Assumes both ports are driven from the same clock domain.
`timescale 1ns/1ps
module ifc_wbuf #(
    parameter int DEPTH = 32,
    parameter int W     = 16,
    parameter int AW    = 5
) (
    input  wire logic          CLK,
    input  wire logic          RSTN,
    input  wire logic          we,
    input  wire logic [AW-1:0] wa,
    input  wire logic [W-1:0]  wd,
    input  wire logic [AW-1:0] ra,
    output logic      [W-1:0]  rd
);
    import ifc_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } ifc_wbuf_st_t;

    ifc_wbuf_st_t st_reg;
    ifc_wbuf_st_t st_next;

    // ------------------------------------------------------------------
    // Storage and read register
    // ------------------------------------------------------------------
    // Read sees the old word on a same-address write
    always_comb begin
        st_next = st_reg;
        st_next.rd = st_reg.mem[ra];
        if (we) begin
            st_next.mem[wa] = wd;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd = st_reg.rd;

endmodule

// ===== rtl/ifc_flash_ctrl.sv
// Flash programming control: AXI4-Lite registers, unlock, erase,
// buffered page write, single-word read and chip reset key.
// Assumes a flash array that acknowledges each held request once.
//
// How it works
// - Data0 high write pushes high:low word into buffer while no operation runs, then bumps address
// - Enable status bit is set only by hardware; writing one is ignored
// - Writing zero to enable status disables erase and write
// - Mode 000 write, 001 erase, 011 read, 110 unlock; rest reserved
// - Unlock trigger starts timer; hardware clears trigger at timeout
// - Write initiate runs selected erase or write, clears on completion
// - Reads only start while read enable is high
// - Read initiate starts a read, cleared when read completes
// - CPU is stalled while a started erase, write or read runs; buffer clear does not stall
// - Writing 55h to the chip key register resets the chip
// - Buffer clear bit clears buffer, hardware drops it when done
// - Upper seven bits of buffer clear register read zero
// - Data0 low write only updates its holding register
// - Address stops incrementing at last word of the page
// - Unlock needs keys 00/0D/C3 low and 04/09/40 high
// - Buffer is cleared automatically after a page write
`timescale 1ns/1ps
module ifc_flash_ctrl #(
    parameter logic [ifc_pkg::TMR_W-1:0] UNLOCK_CYC = ifc_pkg::UNLOCK_CYC_DEF
) (
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    input  wire logic [7:0]              S_AXI_AWADDR,
    input  wire logic                    S_AXI_AWVALID,
    output logic                         S_AXI_AWREADY,
    input  wire logic [31:0]             S_AXI_WDATA,
    input  wire logic [3:0]              S_AXI_WSTRB,
    input  wire logic                    S_AXI_WVALID,
    output logic                         S_AXI_WREADY,
    output logic [1:0]                   S_AXI_BRESP,
    output logic                         S_AXI_BVALID,
    input  wire logic                    S_AXI_BREADY,
    input  wire logic [7:0]              S_AXI_ARADDR,
    input  wire logic                    S_AXI_ARVALID,
    output logic                         S_AXI_ARREADY,
    output logic [31:0]                  S_AXI_RDATA,
    output logic [1:0]                   S_AXI_RRESP,
    output logic                         S_AXI_RVALID,
    input  wire logic                    S_AXI_RREADY,
    output ifc_pkg::ifc_flash_req_t      FL_REQ,
    input  wire logic                    FL_ACK,
    input  wire logic [15:0]             FL_RDATA,
    output logic                         CPU_STALL,
    output logic                         CHIP_RST
);
    import ifc_pkg::*;

    ifc_state_t  st_reg;
    ifc_state_t  st_next;
    logic        m_we;
    logic [4:0]  m_wa;
    logic [15:0] m_wd;
    logic [15:0] m_rd;
    logic [7:0]  wd;
    logic [7:0]  rd_byte;
    logic        w_hit;
    logic        r_hit;
    logic        keys_ok;

    // ------------------------------------------------------------------
    // Write buffer
    // ------------------------------------------------------------------
    ifc_wbuf #(
        .DEPTH (32),
        .W     (16),
        .AW    (5)
    ) u_wbuf (
        .CLK  (CLK),
        .RSTN (RSTN),
        .we   (m_we),
        .wa   (m_wa),
        .wd   (m_wd),
        .ra   (st_reg.idx),
        .rd   (m_rd)
    );

    // ------------------------------------------------------------------
    // Address decode and read-back
    // ------------------------------------------------------------------
    // Map is contiguous words from zero, so a range check suffices
    assign w_hit = (S_AXI_AWADDR <= OFS_BUF_CLR) && (S_AXI_AWADDR[1:0] == 2'h0);
    assign r_hit = (S_AXI_ARADDR <= OFS_BUF_CLR) && (S_AXI_ARADDR[1:0] == 2'h0);
    assign wd    = S_AXI_WDATA[7:0];

    // Key match is only used while the unlock timer runs
    assign keys_ok = (st_reg.lo[1] == KEY1_LO) && (st_reg.hi[1] == KEY1_HI) &&
                     (st_reg.lo[2] == KEY2_LO) && (st_reg.hi[2] == KEY2_HI) &&
                     (st_reg.lo[3] == KEY3_LO) && (st_reg.hi[3] == KEY3_HI);

    always_comb begin
        case (S_AXI_ARADDR)
            OFS_ADDR_LO:  rd_byte = st_reg.addr[7:0];
            OFS_ADDR_HI:  rd_byte = {3'h0, st_reg.addr[12:8]};
            OFS_D0_LO:    rd_byte = st_reg.lo[0];
            OFS_D0_HI:    rd_byte = st_reg.hi[0];
            OFS_D1_LO:    rd_byte = st_reg.lo[1];
            OFS_D1_HI:    rd_byte = st_reg.hi[1];
            OFS_D2_LO:    rd_byte = st_reg.lo[2];
            OFS_D2_HI:    rd_byte = st_reg.hi[2];
            OFS_D3_LO:    rd_byte = st_reg.lo[3];
            OFS_D3_HI:    rd_byte = st_reg.hi[3];
            OFS_OP_CTRL:  rd_byte = {st_reg.ew_en, st_reg.mode, st_reg.trig,
                                     st_reg.winit, st_reg.rden, st_reg.rinit};
            OFS_CHIP_KEY: rd_byte = st_reg.chip_key;
            OFS_BUF_CLR:  rd_byte = {7'h0, st_reg.clr};
            default:      rd_byte = REG_RESET;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.chip_rst = 1'b0;
        m_we = 1'b0;
        m_wa = st_reg.addr[4:0];
        m_wd = {st_reg.hi[0], st_reg.lo[0]};

        // Bus write: address and data are taken together in one cycle
        if (st_reg.aw_rdy) begin
            st_next.aw_rdy = 1'b0;
            st_next.b_vld  = 1'b1;
            st_next.b_resp = w_hit ? RESP_OKAY : RESP_SLVERR;
            if (w_hit && S_AXI_WSTRB[0]) begin
                case (S_AXI_AWADDR)
                    OFS_ADDR_LO: st_next.addr[7:0] = wd;
                    OFS_ADDR_HI: st_next.addr[12:8] = wd[4:0];
                    OFS_D0_LO:   st_next.lo[0] = wd;
                    OFS_D0_HI: begin
                        st_next.hi[0] = wd;
                        // Buffer is frozen while an operation walks it
                        if (st_reg.phase == PH_IDLE) begin
                            m_we = 1'b1;
                            m_wd = {wd, st_reg.lo[0]};
                        end
                        if (st_reg.addr[4:0] != PAGE_LAST) begin
                            st_next.addr = st_reg.addr + 13'h1;
                        end
                    end
                    OFS_D1_LO:   st_next.lo[1] = wd;
                    OFS_D1_HI:   st_next.hi[1] = wd;
                    OFS_D2_LO:   st_next.lo[2] = wd;
                    OFS_D2_HI:   st_next.hi[2] = wd;
                    OFS_D3_LO:   st_next.lo[3] = wd;
                    OFS_D3_HI:   st_next.hi[3] = wd;
                    OFS_OP_CTRL: begin
                        st_next.mode = wd[MODE_LSB +: 3];
                        st_next.rden = wd[RDEN_BIT];
                        // Only a clear reaches the enable status
                        if (!wd[EWEN_BIT]) begin
                            st_next.ew_en = 1'b0;
                        end
                        if (wd[TRIG_BIT] && !st_reg.trig) begin
                            st_next.trig  = 1'b1;
                            st_next.timer = UNLOCK_CYC;
                        end
                        // Forbidden triple set starts nothing
                        if (st_reg.phase == PH_IDLE && !(wd[WINIT_BIT] &&
                            wd[RDEN_BIT] && wd[RINIT_BIT])) begin
                            if (wd[WINIT_BIT] && st_reg.ew_en &&
                                wd[MODE_LSB +: 3] == MODE_ERASE) begin
                                st_next.winit = 1'b1;
                                st_next.stall = 1'b1;
                                st_next.phase = PH_ERASE;
                                st_next.freq.valid = 1'b1;
                                st_next.freq.cmd   = FC_ERASE;
                                st_next.freq.addr  = {st_reg.addr[12:5], 5'h00};
                                st_next.freq.data  = 16'h0000;
                            end else if (wd[WINIT_BIT] && st_reg.ew_en &&
                                wd[MODE_LSB +: 3] == MODE_WRITE) begin
                                st_next.winit = 1'b1;
                                st_next.stall = 1'b1;
                                st_next.phase = PH_FETCH;
                                st_next.idx   = 5'h00;
                            end else if (wd[RINIT_BIT] && wd[RDEN_BIT] &&
                                wd[MODE_LSB +: 3] == MODE_READ) begin
                                st_next.rinit = 1'b1;
                                st_next.stall = 1'b1;
                                st_next.phase = PH_READ;
                                st_next.freq.valid = 1'b1;
                                st_next.freq.cmd   = FC_READ;
                                st_next.freq.addr  = st_reg.addr;
                                st_next.freq.data  = 16'h0000;
                            end
                            // Reserved codes or no enable
                            // start nothing
                        end
                    end
                    OFS_CHIP_KEY: begin
                        st_next.chip_key = wd;
                        if (wd == CHIP_RST_KEY) begin
                            st_next.chip_rst = 1'b1;
                        end
                    end
                    OFS_BUF_CLR: begin
                        if (wd[CLR_BIT] && st_reg.phase == PH_IDLE) begin
                            st_next.clr   = 1'b1;
                            st_next.phase = PH_CLEAR;
                            st_next.idx   = 5'h00;
                        end
                    end
                    default: st_next.b_resp = RESP_SLVERR;
                endcase
            end
        end else if (S_AXI_AWVALID && S_AXI_WVALID && !st_reg.b_vld) begin
            st_next.aw_rdy = 1'b1;
        end
        if (st_reg.b_vld && S_AXI_BREADY) begin
            st_next.b_vld = 1'b0;
        end

        // Bus read: one-cycle ready pulse, data registered with it
        if (st_reg.ar_rdy) begin
            st_next.ar_rdy = 1'b0;
            st_next.r_vld  = 1'b1;
            st_next.r_resp = r_hit ? RESP_OKAY : RESP_SLVERR;
            st_next.r_data = r_hit ? rd_byte : REG_RESET;
        end else if (S_AXI_ARVALID && !st_reg.r_vld) begin
            st_next.ar_rdy = 1'b1;
        end
        if (st_reg.r_vld && S_AXI_RREADY) begin
            st_next.r_vld = 1'b0;
        end

        // Unlock window: keys are compared every cycle it stays open
        if (st_reg.trig) begin
            if (st_reg.mode == MODE_UNLOCK && keys_ok) begin
                st_next.ew_en = 1'b1;
            end
            if (st_reg.timer <= 24'h1) begin
                st_next.trig  = 1'b0;
                st_next.timer = 24'h0;
            end else begin
                st_next.timer = st_reg.timer - 24'h1;
            end
        end

        // Operation sequencer
        case (st_reg.phase)
            PH_IDLE: begin
            end
            PH_ERASE: begin
                if (FL_ACK) begin
                    st_next.freq.valid = 1'b0;
                    st_next.winit = 1'b0;
                    st_next.stall = 1'b0;
                    st_next.phase = PH_IDLE;
                end
            end
            PH_READ: begin
                if (FL_ACK) begin
                    st_next.freq.valid = 1'b0;
                    st_next.lo[0] = FL_RDATA[7:0];
                    st_next.hi[0] = FL_RDATA[15:8];
                    st_next.rinit = 1'b0;
                    st_next.stall = 1'b0;
                    st_next.phase = PH_IDLE;
                end
            end
            PH_FETCH: begin
                // Buffer word for idx lands in its read register now
                st_next.phase = PH_PROG;
            end
            PH_PROG: begin
                if (!st_reg.freq.valid) begin
                    st_next.freq.valid = 1'b1;
                    st_next.freq.cmd   = FC_PROG;
                    st_next.freq.addr  = {st_reg.addr[12:5], st_reg.idx};
                    st_next.freq.data  = m_rd;
                end else if (FL_ACK) begin
                    st_next.freq.valid = 1'b0;
                    if (st_reg.idx == PAGE_LAST) begin
                        st_next.phase = PH_CLEAR;
                        st_next.idx   = 5'h00;
                    end else begin
                        st_next.idx   = st_reg.idx + 5'h01;
                        st_next.phase = PH_FETCH;
                    end
                end
            end
            PH_CLEAR: begin
                // One word per cycle; write initiate and clear bits drop after the last
                m_we = 1'b1;
                m_wa = st_reg.idx;
                m_wd = 16'h0000;
                if (st_reg.idx == PAGE_LAST) begin
                    st_next.clr   = 1'b0;
                    st_next.winit = 1'b0;
                    st_next.stall = 1'b0;
                    st_next.phase = PH_IDLE;
                end else begin
                    st_next.idx = st_reg.idx + 5'h01;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY = st_reg.aw_rdy;
    assign S_AXI_WREADY  = st_reg.aw_rdy;
    assign S_AXI_BVALID  = st_reg.b_vld;
    assign S_AXI_BRESP   = st_reg.b_resp;
    assign S_AXI_ARREADY = st_reg.ar_rdy;
    assign S_AXI_RVALID  = st_reg.r_vld;
    assign S_AXI_RRESP   = st_reg.r_resp;
    assign S_AXI_RDATA   = {24'h000000, st_reg.r_data};
    assign FL_REQ        = st_reg.freq;
    assign CPU_STALL     = st_reg.stall;
    assign CHIP_RST      = st_reg.chip_rst;

endmodule

// ===== test/ifc_checker.sv
// Assertions on the flash request, stall and chip reset ports of the control block.
// Assumes one clock domain and FL_ACK as a one-cycle answer.
`timescale 1ns/1ps
module ifc_checker (
    input wire logic                    CLK,
    input wire logic                    RSTN,
    input wire ifc_pkg::ifc_flash_req_t FL_REQ,
    input wire logic                    FL_ACK,
    input wire logic                    CPU_STALL,
    input wire logic                    CHIP_RST
);
    import ifc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Accepted request, and the quiet fetch gap that follows each word
    sequence s_done; FL_REQ.valid && FL_ACK; endsequence
    sequence s_gap; (!FL_REQ.valid && CPU_STALL) [*2]; endsequence
    property p_stall; FL_REQ.valid |-> CPU_STALL; endproperty
    a_stall: assert property (p_stall)
        else $error("request while CPU runs");
    property p_hold; FL_REQ.valid && !FL_ACK |=> FL_REQ.valid && $stable(FL_REQ); endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before ack");
    property p_drop; s_done |=> !FL_REQ.valid; endproperty
    a_drop: assert property (p_drop)
        else $error("request kept after ack");
    property p_gap; s_done ##0 FL_REQ.cmd == FC_PROG |=> s_gap; endproperty
    a_gap: assert property (p_gap)
        else $error("no fetch gap or stall lost");
    property p_end; s_done ##0 FL_REQ.cmd != FC_PROG |=> !CPU_STALL; endproperty
    a_end: assert property (p_end)
        else $error("stall kept after single op");
    property p_page; FL_REQ.valid && FL_REQ.cmd == FC_ERASE |-> FL_REQ.addr[4:0] == 5'h00;
    endproperty
    a_page: assert property (p_page)
        else $error("erase not page aligned");
    property p_start; $rose(CPU_STALL) |-> ##[0:4] FL_REQ.valid; endproperty
    a_start: assert property (p_start)
        else $error("stall without request");
    property p_pulse; CHIP_RST |=> !CHIP_RST; endproperty
    a_pulse: assert property (p_pulse)
        else $error("chip reset longer than a cycle");
endmodule
bind ifc_flash_ctrl ifc_checker u_ifc_checker (.CLK(CLK), .RSTN(RSTN), .FL_REQ(FL_REQ),
    .FL_ACK(FL_ACK), .CPU_STALL(CPU_STALL), .CHIP_RST(CHIP_RST));

// ===== test/ifc_flash_mdl.sv
// Flash array model: answers a held request after dly cycles.
// Assumes the requester holds each request until it sees ack.
`timescale 1ns/1ps
module ifc_flash_mdl (
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    input  wire ifc_pkg::ifc_flash_req_t req,
    input  wire logic [3:0]              dly,
    output logic                         ack,
    output logic [15:0]                  rdata
);
    import ifc_pkg::*;
    logic [15:0] mem [8192];
    logic [3:0]  wait_reg;
    logic        go;
    assign go = req.valid && !ack && wait_reg >= dly;
    // Idle data line toggles so a stale word never passes as an answer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            {wait_reg, ack, rdata} <= '0;
        end else begin
            ack <= go;
            wait_reg <= (req.valid && !ack && !go) ? wait_reg + 4'h1 : 4'h0;
            rdata <= (go && req.cmd == FC_READ) ? mem[req.addr] : ~rdata;
            if (go && req.cmd == FC_PROG) mem[req.addr] <= req.data;
            for (int i = 0; i < 32; i++)
                if (go && req.cmd == FC_ERASE) mem[{req.addr[12:5], 5'(i)}] <= 16'h0000;
        end
    end
endmodule

// ===== test/ifc_flash_ctrl_tb.sv
// Self-checking bench: AXI4-Lite register traffic against a flash model.
// Assumes the package offsets and a shortened unlock window.
`timescale 1ns/1ps
module ifc_flash_ctrl_tb;
    import ifc_pkg::*;
    localparam logic [23:0] TMR = 24'h3c; // Short window keeps the run brief
    localparam logic [7:0] KV [6] = '{KEY1_LO, KEY1_HI, KEY2_LO, KEY2_HI, KEY3_LO, KEY3_HI};
    logic CLK = 1'b0, RSTN = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic stall, chip_rst, ack;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, page;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] dly = 4'h0;
    logic [1:0] bresp, rresp;
    logic [15:0] read_initiate, w, expw [32];
    ifc_flash_req_t freq;
    int error_cnt = 0, comparisons = 0, cyc = 0, rst_cnt = 0;
    ifc_flash_ctrl #(.UNLOCK_CYC(TMR)) u_ifc_flash_ctrl (
        .CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .FL_REQ(freq), .FL_ACK(ack), .FL_RDATA(read_initiate), .CPU_STALL(stall), .CHIP_RST(chip_rst));
    ifc_flash_mdl u_ifc_flash_mdl (.CLK(CLK), .RSTN(RSTN), .req(freq), .dly(dly),
        .ack(ack), .rdata(read_initiate));
    always #5 CLK = ~CLK;
    // Pulse counter and hang guard
    always @(posedge CLK) begin
        rst_cnt <= rst_cnt + int'(chip_rst === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic check(input logic [33:0] s, input logic [33:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Address and data go out together; each is dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic pa, pw;
        {awaddr, wdata, awvalid, wvalid} <= {a, 24'h000000, d, 2'b11};
        do begin
            @(posedge CLK);
            pa = awvalid && !awready;
            pw = wvalid && !wready;
            {awvalid, wvalid} <= {pa, pw};
        end while (pa || pw);
        bready <= 1'b1;
        do @(posedge CLK); while (!bvalid);
        bready <= 1'b0;
        check(34'(bresp), 34'(er));
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        {araddr, arvalid} <= {a, 1'b1};
        do @(posedge CLK); while (!arready);
        {arvalid, rready} <= 2'b01;
        do @(posedge CLK); while (!rvalid);
        rready <= 1'b0;
        check({rresp, rdata}, {er, 24'h000000, d});
    endtask
    // Launch through the control register, wait out the stall, read back
    task automatic op(input logic [7:0] c, input logic [7:0] e);
        dly <= 4'($urandom_range(6));
        wr(OFS_OP_CTRL, c, RESP_OKAY);
        check(34'(stall), 34'(c[2] & e[7] | &c[1:0]));
        repeat (2) @(posedge CLK);
        while (stall !== 1'b0) @(posedge CLK);
        rchk(OFS_OP_CTRL, e, RESP_OKAY);
    endtask
    initial begin
        void'($urandom(49));
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        for (int i = 0; i < 13; i++) rchk(8'(4 * i), 8'h00, RESP_OKAY);
        rchk(8'h34, 8'h00, RESP_SLVERR);
        wr(8'h32, 8'h5a, RESP_SLVERR);
        op(8'hb1, 8'h30);
        for (int p = 0; p < 2; p++) begin
            wr(OFS_OP_CTRL, 8'h68, RESP_OKAY);
            page = 8'($urandom_range(5));
            for (int k = 0; k < 6; k++)
                wr(OFS_D1_LO + 8'(4 * k), KV[k] ^ 8'(p == 0 && k == page), RESP_OKAY);
            rchk(OFS_OP_CTRL, {p[0], 7'h68}, RESP_OKAY);
            repeat (TMR) @(posedge CLK);
            rchk(OFS_OP_CTRL, {p[0], 7'h60}, RESP_OKAY);
        end
        page = 8'($urandom);
        wr(OFS_ADDR_HI, {3'h0, page[7:3]}, RESP_OKAY);
        wr(OFS_ADDR_LO, {page[2:0], 5'h07}, RESP_OKAY);
        op(8'h94, 8'h90);
        op(8'hb3, 8'hb2);
        rchk(OFS_D0_LO, 8'h00, RESP_OKAY);
        rchk(OFS_D0_HI, 8'h00, RESP_OKAY);
        wr(OFS_BUF_CLR, 8'hff, RESP_OKAY);
        rchk(OFS_BUF_CLR, 8'h01, RESP_OKAY);
        repeat (34) @(posedge CLK);
        rchk(OFS_BUF_CLR, 8'h00, RESP_OKAY);
        op(8'h80, 8'h80);
        wr(OFS_ADDR_LO, {page[2:0], 5'h00}, RESP_OKAY);
        for (int i = 0; i < 33; i++) begin
            w = 16'($urandom);
            expw[(i < 32) ? i : 31] = w;
            wr(OFS_D0_LO, w[7:0], RESP_OKAY);
            rchk(OFS_ADDR_LO, {page[2:0], 5'((i < 31) ? i : 31)}, RESP_OKAY);
            wr(OFS_D0_HI, w[15:8], RESP_OKAY);
        end
        for (int j = 0; j < 2; j++) begin
            op(8'h84, 8'h80);
            for (int i = 0; i < 32; i++)
                check(34'(u_ifc_flash_mdl.mem[{page, 5'(i)}]), j ? 34'h0 : 34'(expw[i]));
        end
        op(8'h00, 8'h00);
        op(8'h04, 8'h00);
        for (int i = 0; i < 4; i++) wr(OFS_CHIP_KEY, 8'($urandom_range(84)), RESP_OKAY);
        wr(OFS_CHIP_KEY, CHIP_RST_KEY, RESP_OKAY);
        rchk(OFS_CHIP_KEY, CHIP_RST_KEY, RESP_OKAY);
        check(34'(rst_cnt), 34'h1);
        end_of_test();
    end
endmodule
